/* File: common/pcio_pkg.sv */
/*
 * Package for the printer control I/O logic: widths, reset values,
 * timing counts, pitch encodings and the packed carriers.
 * Assumes a single 125 MHz system clock.
 */
package pcio_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int ACK_PULSE_NS = 5000;
   localparam int ACK_PULSE_CYC = (ACK_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int BUSY_TO_ACK_NS = 1000;
   localparam int BUSY_TO_ACK_CYC =
      (BUSY_TO_ACK_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_CNT_W = 10;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int HEAD_W = 9;
   localparam int HEAD_CNT_W = 4;
   localparam int SPD_W = 16;
   localparam int LF_W = 8;
   localparam int LF_CNT_W = 4;
   localparam int DIV_W = 3;

   // ---------------------------------------------------------------
   // Print pitch selection and divide ratios (edges per dot)
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PCIO_PITCH_10, PCIO_PITCH_12, PCIO_PITCH_15, PCIO_PITCH_17
   } pcio_pitch_t;
   localparam logic [DIV_W-1:0] DIV_10 = 3'h5;
   localparam logic [DIV_W-1:0] DIV_12 = 3'h4;
   localparam logic [DIV_W-1:0] DIV_15 = 3'h3;
   localparam logic [DIV_W-1:0] DIV_17 = 3'h2;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] data;
   } pcio_byte_t;

   typedef struct packed {
      logic [HEAD_W-1:0] pins;
      logic parity;
   } pcio_head_word_t;

   typedef struct packed {
      logic [SPD_W-1:0] speed;
      logic [LF_W-1:0] lf_phase;
   } pcio_motor_cmd_t;

   localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;
   localparam logic [SPD_W-1:0] SPD_RST = 16'h0000;

endpackage

/* File: hdl/pcio_skid_buf.sv */
/*
 * Two-entry buffer with valid/ready on both sides.
 * Assumes both sides run on sys_clk; the sink may stall at will.
 */
`timescale 1ns/1ps
module pcio_skid_buf (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire pcio_pkg::pcio_byte_t in_data,
   output logic out_valid,
   input wire logic out_ready,
   output pcio_pkg::pcio_byte_t out_data
);
   import pcio_pkg::*;

   pcio_byte_t mem [2];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;

   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem[0] <= '0;
         mem[1] <= '0;
      end else if (clk_en) begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr <= ~wr_ptr;
         end
         if (pop)
            rd_ptr <= ~rd_ptr;
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule // pcio_skid_buf

/* File: hdl/pcio_io_logic.sv */
/*
 * Printer control I/O logic: parallel host port, initialization,
 * encoder dot timing, serial printhead link and motor driver data.
 * Assumes host, encoder and printhead pins are asynchronous to sys_clk
 * and the local processor strobes are synchronous to sys_clk.
 */
// Summary of operation
// R1 - Latch data on falling edge of strobe
// R2 - Hold busy while captured byte is processed
// R3 - Pulse byte-received low to the processor; byte_rx_n is held low until the processor reads the byte
// R4 - Processor read strobe returns held byte
// R5 - Release busy, then pulse acknowledge
// R6 - Keep busy while buffer full or disabled
// R7 - Host never strobes while busy is asserted
// R8 - Initialize at power-up and on host request
// R9 - Power reset, then processor I/O reset
// R10 - Host initialize leaves processor running
// R11 - End of init: ack, serial ready, online
// R12 - Divide encoder edges by pitch ratio
// R13 - Dot pulse times firing and position
// R14 - Shift print data on dot timing
// R15 - Bidirectional head link returns stroke data
// R16 - Head reports parity errors on print data
// R17 - Build motor control data from commands
// R18 - Send line-feed phase data serially
// R19 - Measure encoder pulse width for speed
`timescale 1ns/1ps
module pcio_io_logic (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Host parallel port
   input wire logic [pcio_pkg::DATA_W-1:0] host_data,
   input wire logic host_strobe_n,
   input wire logic host_initialize_n,
   output logic host_busy,
   output logic host_ack_n,
   // Local processor side
   input wire logic io_logic_reset_n,
   input wire logic cpu_rd_n,
   input wire logic rx_enable,
   input wire logic init_done,
   input wire pcio_pkg::pcio_pitch_t pitch_sel,
   output logic byte_rx_n,
   output pcio_pkg::pcio_byte_t cpu_data,
   output logic host_init_req,
   output logic serial_busy_n,
   output logic online_led,
   // Encoder
   input wire logic enc_phase_a,
   input wire logic enc_phase_b,
   output logic dot_timing_pulse,
   output logic [pcio_pkg::SPD_W-1:0] enc_width,
   // Printhead serial link
   input wire pcio_pkg::pcio_head_word_t head_tx_word,
   input wire logic head_tx_load,
   input wire logic head_sdat_i,
   input wire logic head_parity_err,
   output logic head_sdat_o,
   output logic head_sdat_oe,
   output logic head_clk,
   output logic head_tx_busy,
   output logic [pcio_pkg::HEAD_W-1:0] stroke_data,
   output logic parity_err_flag,
   // Motor driver
   input wire pcio_pkg::pcio_motor_cmd_t motor_cmd,
   input wire logic motor_cmd_load,
   output logic [pcio_pkg::SPD_W-1:0] sp_speed,
   output logic lf_sdat,
   output logic lf_sclk,
   output logic lf_latch
);
   import pcio_pkg::*;

   // ---------------------------------------------------------------
   // Resets and pin synchronisers
   // ---------------------------------------------------------------
   // Peripheral reset: power reset, processor I/O reset or host init.
   // The processor never sees the host init as a reset.
   logic [1:0] stb_s, init_s, a_s, b_s, hd_s, pe_s;
   logic [DATA_W-1:0] dat_s1, dat_s2;
   logic stb_d, a_d, b_d;

   wire init_req = !init_s[1];                            // [R8] [R10]
   wire per_rst = !io_logic_reset_n || init_req;          // [R9]

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stb_s <= 2'h3;
         init_s <= 2'h3;
         a_s <= 2'h0;
         b_s <= 2'h0;
         hd_s <= 2'h0;
         pe_s <= 2'h0;
         dat_s1 <= BYTE_RST;
         dat_s2 <= BYTE_RST;
         stb_d <= 1'b1;
         a_d <= 1'b0;
         b_d <= 1'b0;
         host_init_req <= 1'b0;
      end else if (clk_en) begin
         stb_s <= {stb_s[0], host_strobe_n};
         init_s <= {init_s[0], host_initialize_n};
         a_s <= {a_s[0], enc_phase_a};
         b_s <= {b_s[0], enc_phase_b};
         hd_s <= {hd_s[0], head_sdat_i};
         pe_s <= {pe_s[0], head_parity_err};
         dat_s1 <= host_data;
         dat_s2 <= dat_s1;
         stb_d <= stb_s[1];
         a_d <= a_s[1];
         b_d <= b_s[1];
         host_init_req <= init_req;                       // [R10]
      end
   end

   // ---------------------------------------------------------------
   // Parallel host port
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {P_IDLE, P_HOLD, P_GAP, P_ACK} pst_t;
   pst_t pst, next_pst;
   logic [ACK_CNT_W-1:0] pcnt;
   logic ready;
   logic online_ack;
   pcio_byte_t cap;
   logic cap_valid;
   logic buf_ready, buf_valid;
   pcio_byte_t buf_data;

   wire stb_fall = stb_d && !stb_s[1];                    // [R1]
   wire cpu_take = buf_valid && !cpu_rd_n;                // [R4]
   wire hold_done = cap_valid && buf_ready;
   wire room = ready && rx_enable && buf_ready;           // [R6]

   // Gap restarts when room is lost, so a byte ack never starts while busy is high
   assign next_pst =
      (pst == P_IDLE && online_ack) ? P_ACK :             // [R11]
      (pst == P_IDLE && stb_fall) ? P_HOLD :
      (pst == P_HOLD && !cap_valid && room) ? P_GAP :
      (pst == P_GAP && !room) ? P_HOLD :
      (pst == P_GAP && pcnt == ACK_CNT_W'(BUSY_TO_ACK_CYC - 1)) ? P_ACK :
      (pst == P_ACK && pcnt == ACK_CNT_W'(ACK_PULSE_CYC - 1)) ? P_IDLE :
      pst;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pst <= P_IDLE;
         pcnt <= '0;
         cap <= '0;
         cap_valid <= 1'b0;
         ready <= 1'b0;
         online_ack <= 1'b0;
         host_busy <= 1'b1;
         host_ack_n <= 1'b1;
         serial_busy_n <= 1'b0;
         online_led <= 1'b0;
      end else if (clk_en) begin
         if (per_rst) begin
            pst <= P_IDLE;
            pcnt <= '0;
            cap_valid <= 1'b0;
            ready <= 1'b0;
            host_busy <= 1'b1;
            host_ack_n <= 1'b1;
            serial_busy_n <= 1'b0;
            online_led <= 1'b0;
         end else begin
            pst <= next_pst;
            pcnt <= (next_pst != pst) ? '0 : pcnt + 1'b1;
            if (pst == P_IDLE && next_pst == P_HOLD) begin
               cap.data <= dat_s2;                        // [R1]
               cap_valid <= 1'b1;
            end else if (hold_done)
               cap_valid <= 1'b0;
            if (init_done && !ready) begin
               ready <= 1'b1;
               online_ack <= 1'b1;                        // [R11]
               serial_busy_n <= 1'b1;                     // [R11]
               online_led <= 1'b1;                        // [R11]
            end else if (pst == P_ACK)
               online_ack <= 1'b0;
            // Busy covers processing, a full buffer and disabled rx
            host_busy <= !room || next_pst == P_HOLD;     // [R2] [R6]
            // Byte ack only after busy has fallen; the online ack falls with busy
            host_ack_n <= !(next_pst == P_ACK);           // [R5] [R11]
         end
      end
   end

   pcio_skid_buf u_rx_buf (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(cap_valid),
      .in_ready(buf_ready),
      .in_data(cap),
      .out_valid(buf_valid),
      .out_ready(!cpu_rd_n),
      .out_data(buf_data)
   );

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         byte_rx_n <= 1'b1;
         cpu_data <= '0;
      end else if (clk_en) begin
         byte_rx_n <= !(buf_valid && !cpu_take);          // [R3]
         if (cpu_take)
            cpu_data <= buf_data;                         // [R4]
      end
   end

   // ---------------------------------------------------------------
   // Encoder dot timing and width measurement
   // ---------------------------------------------------------------
   logic [DIV_W-1:0] div_cnt;
   logic [SPD_W-1:0] width_cnt;
   wire a_edge = a_s[1] ^ a_d;
   wire enc_edge = a_edge || (b_s[1] ^ b_d);              // [R12]
   wire [DIV_W-1:0] ratio =
      (pitch_sel == PCIO_PITCH_10) ? DIV_10 :
      (pitch_sel == PCIO_PITCH_12) ? DIV_12 :
      (pitch_sel == PCIO_PITCH_15) ? DIV_15 : DIV_17;
   wire div_hit = enc_edge && (div_cnt == ratio - 1'b1);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt <= '0;
         dot_timing_pulse <= 1'b0;
         width_cnt <= SPD_RST;
         enc_width <= SPD_RST;
      end else if (clk_en) begin
         if (per_rst) begin
            div_cnt <= '0;
            dot_timing_pulse <= 1'b0;
         end else begin
            if (enc_edge)
               div_cnt <= div_hit ? '0 : div_cnt + 1'b1;  // [R12]
            dot_timing_pulse <= div_hit;                  // [R13]
         end
         // Saturating so the first width after a stop reads as slowest speed
         if (a_edge) begin
            enc_width <= width_cnt;                       // [R19]
            width_cnt <= SPD_RST;
         end else if (width_cnt != '1)
            width_cnt <= width_cnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Printhead serial link
   // ---------------------------------------------------------------
   // One bit per dot pulse; line turns round to receive stroke bits.
   typedef enum logic [1:0] {H_IDLE, H_TX, H_RX} hst_t;
   hst_t hst;
   logic [HEAD_W:0] hsh;
   logic [HEAD_CNT_W-1:0] hcnt;
   wire [HEAD_CNT_W-1:0] hlast = HEAD_CNT_W'(HEAD_W);

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         hst <= H_IDLE;
         hsh <= '0;
         hcnt <= '0;
         head_sdat_o <= 1'b0;
         head_sdat_oe <= 1'b0;
         head_clk <= 1'b0;
         head_tx_busy <= 1'b0;
         stroke_data <= '0;
         parity_err_flag <= 1'b0;
      end else if (clk_en) begin
         if (per_rst) begin
            hst <= H_IDLE;
            head_sdat_oe <= 1'b0;
            head_clk <= 1'b0;
            head_tx_busy <= 1'b0;
            parity_err_flag <= 1'b0;
         end else begin
            head_clk <= div_hit && hst != H_IDLE;         // [R14]
            if (pe_s[1])
               parity_err_flag <= 1'b1;                   // [R16]
            else if (head_tx_load)
               parity_err_flag <= 1'b0;
            case (hst)
               H_IDLE: begin
                  if (head_tx_load) begin
                     hsh <= head_tx_word;
                     hcnt <= '0;
                     hst <= H_TX;
                     head_tx_busy <= 1'b1;
                     head_sdat_oe <= 1'b1;
                  end
               end
               H_TX: begin
                  if (div_hit) begin                      // [R14]
                     head_sdat_o <= hsh[HEAD_W];
                     hsh <= {hsh[HEAD_W-1:0], 1'b0};
                     hcnt <= hcnt + 1'b1;
                     if (hcnt == hlast) begin
                        hst <= H_RX;
                        hcnt <= '0;
                     end
                  end
               end
               H_RX: begin
                  // Turn round one cycle after the last bit's clock
                  head_sdat_oe <= 1'b0;                   // [R15]
                  if (div_hit) begin
                     stroke_data <= {stroke_data[HEAD_W-2:0],
                        hd_s[1]};                         // [R15]
                     hcnt <= hcnt + 1'b1;
                     if (hcnt == hlast - 1'b1) begin
                        hst <= H_IDLE;
                        head_tx_busy <= 1'b0;
                     end
                  end
               end
               default: hst <= H_IDLE;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // Motor driver data
   // ---------------------------------------------------------------
   logic [LF_W-1:0] lsh;
   logic [LF_CNT_W-1:0] lcnt;
   logic lf_run;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sp_speed <= SPD_RST;
         lsh <= '0;
         lcnt <= '0;
         lf_run <= 1'b0;
         lf_sdat <= 1'b0;
         lf_sclk <= 1'b0;
         lf_latch <= 1'b0;
      end else if (clk_en) begin
         lf_latch <= 1'b0;
         if (per_rst) begin
            sp_speed <= SPD_RST;
            lf_run <= 1'b0;
            lf_sclk <= 1'b0;
         end else if (motor_cmd_load && !lf_run) begin
            sp_speed <= motor_cmd.speed;                  // [R17]
            lf_sdat <= motor_cmd.lf_phase[LF_W-1];        // [R18]
            lsh <= {motor_cmd.lf_phase[LF_W-2:0], 1'b0};
            lcnt <= '0;
            lf_run <= 1'b1;
         end else if (lf_run) begin
            // Data moves on the falling clock, half a period before
            // the driver samples it on the rise
            lf_sclk <= !lf_sclk;
            if (lf_sclk) begin
               lf_sdat <= lsh[LF_W-1];                    // [R18]
               lsh <= {lsh[LF_W-2:0], 1'b0};
               lcnt <= lcnt + 1'b1;
               if (lcnt == LF_CNT_W'(LF_W - 1)) begin
                  lf_run <= 1'b0;
                  lf_latch <= 1'b1;                       // [R18]
               end
            end
         end
      end
   end

endmodule // pcio_io_logic

/* File: dv/pcio_io_monitor.sv */
/* Checker of host port, init and serial outputs of pcio_io_logic.
   Assumes one clock domain and clk_en held high by the bench. */
`timescale 1ns/1ps
module pcio_io_monitor (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic host_strobe_n,
   input wire logic rx_enable,
   input wire logic host_busy,
   input wire logic host_ack_n,
   input wire logic byte_rx_n,
   input wire logic host_init_req,
   input wire logic serial_busy_n,
   input wire logic online_led,
   input wire logic dot_timing_pulse,
   input wire logic head_sdat_oe,
   input wire logic head_tx_busy,
   input wire logic lf_latch
);
   import pcio_pkg::*;
   // ----
   // Ack width counter
   // ----
   logic [ACK_CNT_W-1:0] ack_low;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b)
         ack_low <= '0;
      else if (host_ack_n)
         ack_low <= '0;
      else
         ack_low <= ack_low + 1'b1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   ack_width_a: assert property (
      $rose(host_ack_n) |-> ack_low == ACK_CNT_W'(ACK_PULSE_CYC))
      else $error("ack pulse width wrong");
   busy_then_ack_a: assert property (
      $fell(host_ack_n) && $past(online_led, 8)
      |-> !$past(host_busy, 1) && !$past(host_busy, 120))
      else $error("ack not preceded by busy release");
   busy_off_rx_a: assert property (
      !rx_enable [*3] |-> host_busy)
      else $error("busy low while reception disabled");
   busy_capture_a: assert property (
      $fell(host_strobe_n) && !host_busy && host_ack_n
      |-> ##[1:6] host_busy)
      else $error("no busy after strobe");
   rx_notice_a: assert property (
      $fell(host_strobe_n) && !host_busy && host_ack_n
      |-> ##[2:8] !byte_rx_n)
      else $error("byte not announced");
   online_ready_a: assert property (
      online_led |-> serial_busy_n)
      else $error("online without serial ready");
   host_init_a: assert property (
      host_init_req [*2] |-> host_busy && host_ack_n && byte_rx_n)
      else $error("peripheral not held in host init");
   dot_pulse_a: assert property (
      dot_timing_pulse |=> !dot_timing_pulse)
      else $error("dot pulse too long");
   head_oe_a: assert property (
      head_sdat_oe |-> head_tx_busy)
      else $error("head driven while idle");
   lf_latch_a: assert property (
      lf_latch |=> !lf_latch)
      else $error("latch pulse too long");
endmodule // pcio_io_monitor

/* File: dv/pcio_host_model.sv */
/* Host computer on the parallel port: strobes bytes, pulses init.
   Assumes the bench calls its tasks; drives on rising edges. */
`timescale 1ns/1ps
module pcio_host_model (
   input wire logic sys_clk,
   input wire logic host_busy,
   input wire logic host_ack_n,
   output logic [pcio_pkg::DATA_W-1:0] host_data,
   output logic host_strobe_n,
   output logic host_initialize_n
);
   import pcio_pkg::*;
   bit pending;
   initial begin
      host_data = 8'h5A;
      host_strobe_n = 1'b1;
      host_initialize_n = 1'b1;
   end
   always @(negedge host_ack_n) pending = 1'b0;
   task automatic send(input logic [DATA_W-1:0] b);
      @(posedge sys_clk);
      while (pending || host_busy || !host_ack_n) @(posedge sys_clk);
      host_data <= b;
      @(posedge sys_clk);
      host_strobe_n <= 1'b0;
      pending = 1'b1;
      repeat (4) @(posedge sys_clk);
      host_strobe_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      // Released lines must not keep showing the byte
      host_data <= ~b;
   endtask
   task automatic init_pulse(input int n);
      @(posedge sys_clk);
      host_initialize_n <= 1'b0;
      repeat (n) @(posedge sys_clk);
      host_initialize_n <= 1'b1;
   endtask
endmodule // pcio_host_model

/* File: dv/testbench.sv */
/* Self-checking bench for pcio_io_logic with the host model.
   Drives on rising edges, checks on falling edges, 125 MHz. */
`timescale 1ns/1ps
module testbench;
   import pcio_pkg::*;
   logic sys_clk, rst_b, io_logic_reset_n, cpu_rd_n, rx_enable, init_done;
   logic [DATA_W-1:0] host_data;
   logic host_strobe_n, host_initialize_n, host_busy, host_ack_n;
   logic byte_rx_n, host_init_req, serial_busy_n, online_led;
   pcio_pitch_t pitch_sel;
   pcio_byte_t cpu_data;
   logic enc_phase_a, enc_phase_b, dot_timing_pulse;
   logic [SPD_W-1:0] enc_width, sp_speed;
   pcio_head_word_t head_tx_word;
   logic head_tx_load, head_parity_err, head_sdat_o, head_sdat_oe;
   logic head_clk, head_tx_busy, parity_err_flag;
   logic [HEAD_W-1:0] stroke_data;
   pcio_motor_cmd_t motor_cmd;
   logic motor_cmd_load, lf_sdat, lf_sclk, lf_latch;
   wire logic head_sdat_i;
   int err_count, n_checks, dots, obits_n;
   logic [9:0] obits;
   // ----
   // Wiring
   // ----
   // The head drives ones back while the design has released the line
   assign head_sdat_i = head_sdat_oe ? head_sdat_o : 1'b1;
   pcio_io_logic dut (.sys_clk, .rst_b, .clk_en(1'b1), .host_data,
      .host_strobe_n, .host_initialize_n, .host_busy, .host_ack_n,
      .io_logic_reset_n, .cpu_rd_n, .rx_enable, .init_done, .pitch_sel,
      .byte_rx_n, .cpu_data, .host_init_req, .serial_busy_n, .online_led,
      .enc_phase_a, .enc_phase_b, .dot_timing_pulse, .enc_width,
      .head_tx_word, .head_tx_load, .head_sdat_i, .head_parity_err,
      .head_sdat_o, .head_sdat_oe, .head_clk, .head_tx_busy, .stroke_data,
      .parity_err_flag, .motor_cmd, .motor_cmd_load, .sp_speed, .lf_sdat,
      .lf_sclk, .lf_latch);
   pcio_host_model hm (.sys_clk, .host_busy, .host_ack_n, .host_data,
      .host_strobe_n, .host_initialize_n);
   // ----
   // Helpers
   // ----
   task automatic chk(input logic [15:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] e);
      @(posedge sys_clk);
      cpu_rd_n <= 1'b0;
      @(posedge sys_clk);
      cpu_rd_n <= 1'b1;
      cyc(2);
      chk(cpu_data.data, e, "read data");
   endtask
   task automatic enc(input int n);
      for (int k = 0; k < n; k++) begin
         @(posedge sys_clk);
         if (k % 2)
            enc_phase_b <= ~enc_phase_b;
         else
            enc_phase_a <= ~enc_phase_a;
         repeat (8) begin
            @(negedge sys_clk);
            dots += dot_timing_pulse;
            if (head_clk && head_sdat_oe) begin
               obits = {obits[8:0], head_sdat_o};
               obits_n++;
            end
         end
      end
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      cyc(2);
      chk({host_busy, host_ack_n, byte_rx_n}, 3'h7, "reset port");
      chk({serial_busy_n, online_led}, 2'b00, "reset online");
      @(posedge sys_clk);
      io_logic_reset_n <= 1'b1;
      cyc(4);
      chk(host_busy, 1'b1, "busy before init");
   endtask
   task automatic t_init;
      int i;
      @(posedge sys_clk);
      init_done <= 1'b1;
      for (i = 0; i < 1000 && host_ack_n; i++) @(negedge sys_clk);
      chk(host_ack_n, 1'b0, "online ack");
      chk({serial_busy_n, online_led}, 2'b11, "online");
      chk(host_busy, 1'b0, "busy after init");
   endtask
   task automatic t_byte;
      int i;
      hm.send(8'hA5);
      for (i = 0; i < 20 && byte_rx_n; i++) @(negedge sys_clk);
      chk(byte_rx_n, 1'b0, "byte announced");
      for (i = 0; i < 400 && host_ack_n; i++) @(negedge sys_clk);
      chk({host_busy, host_ack_n}, 2'b00, "busy off, ack");
      rd(8'hA5);
      chk(byte_rx_n, 1'b1, "buffer empty");
   endtask
   task automatic t_full;
      int i;
      hm.send(8'h3C);
      hm.send(8'hC3);
      cyc(800);
      chk(host_busy, 1'b1, "busy while full");
      rd(8'h3C);
      rd(8'hC3);
      for (i = 0; i < 300 && host_busy; i++) @(negedge sys_clk);
      chk(host_busy, 1'b0, "busy released");
      @(posedge sys_clk);
      rx_enable <= 1'b0;
      cyc(10);
      chk(host_busy, 1'b1, "busy when disabled");
      @(posedge sys_clk);
      rx_enable <= 1'b1;
      cyc(900);
   endtask
   task automatic t_motor;
      int i;
      int n = 0;
      logic [7:0] bits = '0;
      logic prev = 1'b0;
      logic lat = 1'b0;
      @(posedge sys_clk);
      motor_cmd <= '{speed: 16'h1234, lf_phase: 8'hB6};
      motor_cmd_load <= 1'b1;
      @(posedge sys_clk);
      motor_cmd_load <= 1'b0;
      for (i = 0; i < 40 && !lat; i++) begin
         @(negedge sys_clk);
         if (lf_sclk && !prev) begin
            bits = {bits[6:0], lf_sdat};
            n++;
         end
         prev = lf_sclk;
         lat = lf_latch;
      end
      chk(sp_speed, 16'h1234, "speed command");
      chk(bits, 8'hB6, "phase bits");
      chk(16'(n), 16'h0008, "phase bit count");
      chk(lat, 1'b1, "latch pulse");
   endtask
   task automatic t_dot;
      logic [DIV_W-1:0] dv [4] = '{DIV_10, DIV_12, DIV_15, DIV_17};
      for (int p = 0; p < 4; p++) begin
         // Let the online ack of the last reset run to its end
         while (!host_ack_n) cyc(1);
         @(posedge sys_clk);
         pitch_sel <= pcio_pitch_t'(p);
         io_logic_reset_n <= 1'b0;
         repeat (8) @(posedge sys_clk);
         io_logic_reset_n <= 1'b1;
         dots = 0;
         enc(60);
         chk(16'(dots), 16'(60 / dv[p]), "dot count");
      end
      chk(enc_width, 16'h000F, "edge spacing");
   endtask
   task automatic t_head;
      @(posedge sys_clk);
      head_tx_word <= '{pins: 9'h1A5, parity: 1'b1};
      head_tx_load <= 1'b1;
      head_parity_err <= 1'b1;
      @(posedge sys_clk);
      head_tx_load <= 1'b0;
      obits_n = 0;
      enc(60);
      @(posedge sys_clk);
      head_parity_err <= 1'b0;
      cyc(1);
      chk(obits, 10'h34B, "head bits out");
      chk(16'(obits_n), 16'h000A, "bits on dot pulses");
      chk(head_tx_busy, 1'b0, "head link done");
      chk(stroke_data, 9'h1FF, "stroke data");
      chk(parity_err_flag, 1'b1, "parity error kept");
   endtask
   task automatic t_hostinit;
      fork
         hm.init_pulse(12);
         begin
            cyc(8);
            chk({host_init_req, host_busy}, 2'b11, "host init");
         end
      join
      cyc(8);
      chk(host_init_req, 1'b0, "host init over");
   endtask
   // ----
   // Run
   // ----
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      rst_b = 1'b0;
      io_logic_reset_n = 1'b0;
      cpu_rd_n = 1'b1;
      rx_enable = 1'b1;
      init_done = 1'b0;
      pitch_sel = PCIO_PITCH_10;
      enc_phase_a = 1'b0;
      enc_phase_b = 1'b0;
      head_tx_word = '0;
      head_tx_load = 1'b0;
      head_parity_err = 1'b0;
      motor_cmd = '0;
      motor_cmd_load = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_reset();
      t_init();
      t_byte();
      t_full();
      t_motor();
      t_dot();
      t_head();
      t_hostinit();
      stop_test();
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end
endmodule // testbench
bind pcio_io_logic pcio_io_monitor u_mon (.sys_clk, .rst_b, .host_strobe_n,
   .rx_enable, .host_busy, .host_ack_n, .byte_rx_n, .host_init_req,
   .serial_busy_n, .online_led, .dot_timing_pulse, .head_sdat_oe,
   .head_tx_busy, .lf_latch);
